// ---- logic/dpsb_pkg.sv ----
// How it works
// - An L1 access hitting a stream may re-fetch the other 64-byte half.
// - Eight stream entries, each a 128-byte line of two halves with state.
// - The allocation pointer names the oldest entry, reallocated next.
// - Read to X hitting candidate allocates stream at X+64; fetch X+64, X+128.
// - Reallocation marks earlier outstanding fetches stale; one live per slot.
// - Stale marking holds when old fetch leaves as new one enters.
// - Re-fetch only for L1 accesses; L2 controller requests re-fetch only without a usable L2.
// - Cleared region enable suppresses prefetch; accesses still go out cached.
// - Enable bits of region entries 12-15 reset to one.
// - Region attribute writes are taken only in supervisor mode.
// - L2 disabled, sized zero or frozen gives L1 half-line behaviour.
// - A write matching a stream invalidates prefetched data for it.
// - Match with no data and nothing outstanding is forwarded to memory.
// - Match with outstanding fetch waits; served from the buffer, or forwarded to memory if the fetch fails.
// - When two prefetches collide in the pipeline the earlier is dropped.
package dpsb_pkg;

  // ****************************************************************
  // Geometry and timing-free constants
  // ****************************************************************
  localparam int ADDR_W       = 32;
  localparam int NUM_ENTRIES  = 8;
  localparam int LINE_BYTES   = 128;
  localparam int HALF_BYTES   = 64;
  localparam int HALVES       = LINE_BYTES / HALF_BYTES;
  localparam int HALF_SHIFT   = $clog2(HALF_BYTES);
  localparam int LINE_W       = ADDR_W - HALF_SHIFT;
  localparam int ENT_W        = $clog2(NUM_ENTRIES);
  localparam int SLOT_W       = ENT_W + $clog2(HALVES);
  localparam int NUM_SLOTS    = NUM_ENTRIES * HALVES;
  localparam int GEN_W        = 3;
  localparam int REGION_SHIFT = 24;
  localparam int NUM_REGIONS  = 256;
  localparam int REGION_W     = $clog2(NUM_REGIONS);

  // Region enables: entries 12 to 15 start set, all others clear.
  localparam logic [NUM_REGIONS-1:0] PF_ENABLE_RESET =
    {{(NUM_REGIONS-16){1'b0}}, 16'hf000};

  typedef enum logic [1:0] {
    FSM_IDLE,
    FSM_WAIT,
    FSM_FWD
  } dpsb_fsm_e;

endpackage

// ---- logic/dpsb_slot_match.sv ----
module dpsb_slot_match #(
  parameter int NE = 8,
  parameter int LW = 26
) (
  // Lookup address, in half-line units
  input  wire logic [LW-1:0]          line,
  // Entry table
  input  wire logic [NE-1:0]          ent_v,
  input  wire logic [NE-1:0][LW-1:0]  ent_line,
  // Result
  output logic                        hit,
  output logic [$clog2(NE)-1:0]       hit_ent,
  output logic                        hit_half
);

  logic [NE-1:0] m0;
  logic [NE-1:0] m1;

  // Each entry compares both of its halves in parallel.
  for (genvar i = 0; i < NE; i++) begin : g_cmp
    assign m0[i] = ent_v[i] && (line == ent_line[i]);
    assign m1[i] = ent_v[i] && (line == LW'(ent_line[i] + 1'b1));
  end

  // Lowest matching entry wins; entries never overlap in normal use.
  always_comb begin
    hit      = 1'b0;
    hit_ent  = '0;
    hit_half = 1'b0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (m0[i] || m1[i]) begin
        hit      = 1'b1;
        hit_ent  = ($clog2(NE))'(i);
        hit_half = m1[i] && !m0[i];
      end
    end
  end

endmodule

// ---- logic/dpsb_top.sv ----
module dpsb_top #(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // Demand access from the core caches
  input  wire logic                         acc_valid,
  output logic                              acc_ready,
  input  wire logic [dpsb_pkg::ADDR_W-1:0]  acc_addr,
  input  wire logic                         acc_write,
  input  wire logic                         acc_from_l2,
  // Level-2 cache state
  input  wire logic                         l2_enabled,
  input  wire logic                         l2_size_zero,
  input  wire logic                         l2_frozen,
  // Region attribute write port
  input  wire logic                         attr_wr,
  input  wire logic [dpsb_pkg::REGION_W-1:0] attr_idx,
  input  wire logic                         attr_pf_enable,
  input  wire logic                         supervisor,
  // Buffer hit answer
  output logic                              rsp_valid,
  output logic [DATA_W-1:0]                 rsp_data,
  // Demand forwarded to the shared memory controller
  output logic                              fwd_valid,
  input  wire logic                         fwd_ready,
  output logic [dpsb_pkg::ADDR_W-1:0]       fwd_addr,
  output logic                              fwd_write,
  // Prefetch request to the shared memory controller
  output logic                              pf_valid,
  input  wire logic                         pf_ready,
  output logic [dpsb_pkg::ADDR_W-1:0]       pf_addr,
  output logic [dpsb_pkg::SLOT_W-1:0]       pf_slot,
  output logic [dpsb_pkg::GEN_W-1:0]        pf_gen,
  // Prefetch return
  input  wire logic                         ret_valid,
  input  wire logic [dpsb_pkg::SLOT_W-1:0]  ret_slot,
  input  wire logic [dpsb_pkg::GEN_W-1:0]   ret_gen,
  input  wire logic                         ret_ok,
  input  wire logic [DATA_W-1:0]            ret_data
);
  import dpsb_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    dpsb_fsm_e                          fsm;
    logic [NUM_REGIONS-1:0]             pf_enable;
    logic [NUM_ENTRIES-1:0]             ent_v;
    logic [NUM_ENTRIES-1:0][LINE_W-1:0] ent_line;
    logic [NUM_SLOTS-1:0]               dat_v;
    logic [NUM_SLOTS-1:0]               pend;
    logic [NUM_SLOTS-1:0][GEN_W-1:0]    gen;
    logic [NUM_SLOTS-1:0][DATA_W-1:0]   dat;
    logic [ENT_W-1:0]                   alloc_ptr;
    logic                               cand_v;
    logic [LINE_W-1:0]                  cand_line;
    logic                               fol_v;
    logic [LINE_W-1:0]                  fol_line;
    logic [SLOT_W-1:0]                  fol_slot;
    logic                               pf_v;
    logic [LINE_W-1:0]                  pf_line;
    logic [SLOT_W-1:0]                  pf_slot;
    logic [GEN_W-1:0]                   pf_gen;
    logic [SLOT_W-1:0]                  wait_slot;
    logic                               rsp_v;
    logic [DATA_W-1:0]                  rsp_data;
    logic                               fwd_v;
    logic                               fwd_wr;
    logic [ADDR_W-1:0]                  fwd_addr;
  } dpsb_state_s;

  dpsb_state_s st;
  dpsb_state_s next_st;

  // ****************************************************************
  // Lookup and access classification
  // ****************************************************************
  logic [LINE_W-1:0] acc_line;
  logic              hit;
  logic [ENT_W-1:0]  hit_ent;
  logic              hit_half;
  logic [SLOT_W-1:0] hit_slot;
  logic [SLOT_W-1:0] oth_slot;
  logic [LINE_W-1:0] oth_line;
  logic              pf_en;
  logic              l1_mode;
  logic              acc_fire;
  logic              cand_hit;
  logic              refetch_ok;
  logic              alloc_fire;
  logic              req_v;
  logic [LINE_W-1:0] req_line;
  logic [SLOT_W-1:0] req_slot;
  logic [GEN_W-1:0]  old_gen0;

  assign acc_line = acc_addr[ADDR_W-1:HALF_SHIFT];

  dpsb_slot_match #(
    .NE (NUM_ENTRIES),
    .LW (LINE_W)
  ) u_match (
    .line     (acc_line),
    .ent_v    (st.ent_v),
    .ent_line (st.ent_line),
    .hit      (hit),
    .hit_ent  (hit_ent),
    .hit_half (hit_half)
  );

  // Slot of the matched half and of its partner half in the same line.
  assign hit_slot = {hit_ent, hit_half};
  assign oth_slot = {hit_ent, ~hit_half};
  assign oth_line = LINE_W'(st.ent_line[hit_ent] + {{(LINE_W-1){1'b0}},
                                                   ~hit_half});
  assign pf_en    = st.pf_enable[acc_addr[ADDR_W-1:REGION_SHIFT]];
  // Without a usable L2 every access is treated the L1 way.
  assign l1_mode  = !acc_from_l2 || !l2_enabled || l2_size_zero ||
                    l2_frozen;
  // The follow-on fetch owns the request stage, so demand waits a cycle.
  assign acc_ready = (st.fsm == FSM_IDLE) && !st.fol_v;
  assign acc_fire  = acc_valid && acc_ready;
  assign cand_hit  = st.cand_v &&
                     (acc_line == LINE_W'(st.cand_line + 1'b1));
  // Re-fetch the empty partner half for reads in L1 mode only.
  assign refetch_ok = acc_fire && !acc_write && hit && pf_en && l1_mode &&
                      !st.dat_v[oth_slot] && !st.pend[oth_slot];
  assign alloc_fire = acc_fire && !acc_write && !hit && pf_en &&
                      cand_hit;
  assign old_gen0   = st.gen[{st.alloc_ptr, 1'b0}];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st  = st;
    next_st.rsp_v = 1'b0;
    req_v    = 1'b0;
    req_line = '0;
    req_slot = '0;

    // Returns count only while their generation is still current.
    if (ret_valid && st.pend[ret_slot] &&
        ret_gen == st.gen[ret_slot]) begin
      next_st.pend[ret_slot] = 1'b0;
      if (ret_ok) begin
        next_st.dat_v[ret_slot] = 1'b1;
        next_st.dat[ret_slot]   = ret_data;
      end
    end

    // Attribute writes outside supervisor mode are dropped silently.
    if (attr_wr && supervisor) begin
      next_st.pf_enable[attr_idx] = attr_pf_enable;
    end

    // Second fetch of a fresh stream goes out one cycle after the first.
    if (st.fol_v) begin
      req_v         = 1'b1;
      req_line      = st.fol_line;
      req_slot      = st.fol_slot;
      next_st.fol_v = 1'b0;
    end

    unique case (st.fsm)
      FSM_IDLE: begin
        if (acc_fire) begin
          next_st.fwd_addr = acc_addr;
          next_st.fwd_wr   = acc_write;
          if (acc_write) begin
            // Bumping the generation also kills any fetch in flight.
            if (hit) begin
              next_st.dat_v[hit_slot] = 1'b0;
              next_st.pend[hit_slot]  = 1'b0;
              next_st.gen[hit_slot]   = GEN_W'(st.gen[hit_slot] + 1'b1);
            end
            next_st.fwd_v = 1'b1;
            next_st.fsm   = FSM_FWD;
          end else if (hit && st.dat_v[hit_slot]) begin
            next_st.rsp_v    = 1'b1;
            next_st.rsp_data = st.dat[hit_slot];
          end else if (hit && st.pend[hit_slot]) begin
            next_st.wait_slot = hit_slot;
            next_st.fsm       = FSM_WAIT;
          end else begin
            // Address hit or miss: out to memory, still cacheable.
            next_st.fwd_v = 1'b1;
            next_st.fsm   = FSM_FWD;
            if (alloc_fire) begin
              for (int h = 0; h < HALVES; h++) begin
                next_st.dat_v[{st.alloc_ptr, h[0]}] = 1'b0;
                next_st.pend[{st.alloc_ptr, h[0]}]  = 1'b0;
                next_st.gen[{st.alloc_ptr, h[0]}]   =
                  GEN_W'(st.gen[{st.alloc_ptr, h[0]}] + 1'b1);
              end
              next_st.ent_v[st.alloc_ptr]    = 1'b1;
              next_st.ent_line[st.alloc_ptr] = LINE_W'(acc_line + 1'b1);
              next_st.alloc_ptr = ENT_W'(st.alloc_ptr + 1'b1);
              next_st.cand_v    = 1'b0;
              req_v             = 1'b1;
              req_line          = LINE_W'(acc_line + 1'b1);
              req_slot          = {st.alloc_ptr, 1'b0};
              next_st.fol_v     = 1'b1;
              next_st.fol_line  = LINE_W'(acc_line + 2'd2);
              next_st.fol_slot  = {st.alloc_ptr, 1'b1};
            end else if (!hit && pf_en) begin
              next_st.cand_v    = 1'b1;
              next_st.cand_line = acc_line;
            end
          end
          if (refetch_ok) begin
            req_v    = 1'b1;
            req_line = oth_line;
            req_slot = oth_slot;
          end
        end
      end
      FSM_WAIT: begin
        if (st.dat_v[st.wait_slot]) begin
          next_st.rsp_v    = 1'b1;
          next_st.rsp_data = st.dat[st.wait_slot];
          next_st.fsm      = FSM_IDLE;
        end else if (!st.pend[st.wait_slot]) begin
          next_st.fwd_v = 1'b1;
          next_st.fsm   = FSM_FWD;
        end
      end
      FSM_FWD: begin
        if (fwd_ready) begin
          next_st.fwd_v = 1'b0;
          next_st.fsm   = FSM_IDLE;
        end
      end
    endcase

    // A new fetch displaces a stalled one; the loser's slot goes empty.
    if (req_v) begin
      if (st.pf_v && !pf_ready &&
          next_st.gen[st.pf_slot] == st.pf_gen) begin
        next_st.pend[st.pf_slot] = 1'b0;
      end
      next_st.pf_v           = 1'b1;
      next_st.pf_line        = req_line;
      next_st.pf_slot        = req_slot;
      next_st.pf_gen         = next_st.gen[req_slot];
      next_st.pend[req_slot] = 1'b1;
    end else if (st.pf_v && pf_ready) begin
      next_st.pf_v = 1'b0;
    end
  end

  // Synchronous reset; region enables take their power-up pattern.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st           <= '0;
      st.pf_enable <= PF_ENABLE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rsp_valid = st.rsp_v;
  assign rsp_data  = st.rsp_data;
  assign fwd_valid = st.fwd_v;
  assign fwd_addr  = st.fwd_addr;
  assign fwd_write = st.fwd_wr;
  assign pf_valid  = st.pf_v;
  assign pf_addr   = {st.pf_line, {HALF_SHIFT{1'b0}}};
  assign pf_slot   = st.pf_slot;
  assign pf_gen    = st.pf_gen;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_REFETCH_ISSUED: assert property (
    refetch_ok |=> pf_valid && pf_slot == $past(oth_slot))
    else $error("re-fetch of partner half not issued");
  AST_ALLOC_CLEARS: assert property (
    alloc_fire |=> st.ent_v[$past(st.alloc_ptr)] &&
                   !st.dat_v[{$past(st.alloc_ptr), 1'b1}])
    else $error("allocated entry not fresh");
  AST_PTR_ADVANCE: assert property (
    alloc_fire |=> st.alloc_ptr == ENT_W'($past(st.alloc_ptr) + 1'b1))
    else $error("allocation pointer did not advance");
  AST_STREAM_FETCHES: assert property (
    alloc_fire |=> pf_addr[ADDR_W-1:HALF_SHIFT] ==
                   LINE_W'($past(acc_line) + 1'b1)
               ##1 pf_valid && pf_addr[ADDR_W-1:HALF_SHIFT] ==
                   LINE_W'($past(acc_line, 2) + 2'd2))
    else $error("stream fetches X+64 then X+128 missing");
  AST_REALLOC_STALE: assert property (
    alloc_fire |=> st.gen[{$past(st.alloc_ptr), 1'b0}] != $past(old_gen0))
    else $error("reallocation left old fetch live");
  AST_SAME_EDGE: assert property (
    alloc_fire && pf_valid && pf_ready &&
    pf_slot == {st.alloc_ptr, 1'b0}
    |=> st.gen[$past(pf_slot)] != $past(pf_gen))
    else $error("departing fetch not marked stale");
  AST_L2_NO_REFETCH: assert property (
    acc_fire && acc_from_l2 && l2_enabled && !l2_size_zero && !l2_frozen
    |-> !refetch_ok)
    else $error("L2 request triggered re-fetch");
  AST_REGION_OFF: assert property (
    acc_fire && !pf_en && !acc_write && !hit |=> fwd_valid && !st.fol_v)
    else $error("disabled region prefetched or not forwarded");
  AST_RESET_ENABLE: assert property (
    $past(sys_rst) |-> st.pf_enable[15:12] == 4'hf)
    else $error("region 12-15 enable not set after reset");
  AST_USER_WRITE: assert property (
    attr_wr && !supervisor && !$past(sys_rst)
    |=> st.pf_enable == $past(st.pf_enable))
    else $error("attribute write taken outside supervisor mode");
  AST_WRITE_INV: assert property (
    acc_fire && acc_write && hit |=> !st.dat_v[$past(hit_slot)])
    else $error("write left prefetched data valid");
  AST_WAIT_SERVED: assert property (
    st.fsm == FSM_WAIT && st.dat_v[st.wait_slot] |=> rsp_valid)
    else $error("waiting access not served on return");
  AST_FAIL_FWD: assert property (
    st.fsm == FSM_WAIT && !st.pend[st.wait_slot] &&
    !st.dat_v[st.wait_slot] |=> fwd_valid)
    else $error("failed fetch did not fall back to memory");
  AST_COLLIDE: assert property (
    req_v && pf_valid && !pf_ready |=> pf_slot == $past(req_slot))
    else $error("earlier fetch not displaced");
  AST_STALE_DROP: assert property (
    ret_valid && ret_gen != st.gen[ret_slot] |=> st.dat == $past(st.dat))
    else $error("stale return written into buffer");

  COV_ALLOC: cover property (alloc_fire ##1 st.fol_v);
  COV_REFETCH: cover property (refetch_ok);
  COV_WAIT_HIT: cover property (st.fsm == FSM_WAIT ##1 rsp_valid);
  COV_COLLIDE: cover property (req_v && pf_valid && !pf_ready);

endmodule

// ---- bench/dpsb_mem_model.sv ----
module dpsb_mem_model #(
  parameter int DATA_W = 64
) (
  // Clock, reset and bench controls
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [3:0]                  lat,
  input  wire logic                        pf_en,
  input  wire logic                        ok_en,
  // Demand forward handshake
  input  wire logic                        fwd_valid,
  output logic                             fwd_ready,
  // Prefetch request and return
  input  wire logic                        pf_valid,
  output logic                             pf_ready,
  input  wire logic [dpsb_pkg::ADDR_W-1:0] pf_addr,
  input  wire logic [dpsb_pkg::SLOT_W-1:0] pf_slot,
  input  wire logic [dpsb_pkg::GEN_W-1:0]  pf_gen,
  output logic                             ret_valid,
  output logic [dpsb_pkg::SLOT_W-1:0]      ret_slot,
  output logic [dpsb_pkg::GEN_W-1:0]       ret_gen,
  output logic                             ret_ok,
  output logic [DATA_W-1:0]                ret_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import dpsb_pkg::*;

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [GEN_W-1:0]  gen;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       due;
  } dpsb_fetch_s;

  dpsb_fetch_s q [$];
  logic [31:0] cyc;
  logic [3:0]  cnt;

  // A stalled far side withholds ready; a request is never half taken.
  assign pf_ready = pf_en;

  // Demands are acknowledged lat+1 cycles after fwd_valid rises; fetches return in order.
  always @(posedge clk) begin
    if (sys_rst) begin
      q.delete();
      cyc       <= '0;
      fwd_ready <= 1'b0;
      cnt       <= '0;
      ret_valid <= 1'b0;
      {ret_slot, ret_gen, ret_ok, ret_data} <= '0;
    end else begin
      cyc <= cyc + 1;
      if (fwd_valid && !fwd_ready && cnt < lat) begin
        cnt <= cnt + 1;
      end else begin
        fwd_ready <= fwd_valid && !fwd_ready;
        cnt       <= '0;
      end
      if (pf_valid && pf_ready) begin
        q.push_back({pf_slot, pf_gen, pf_addr, cyc + 32'(lat)});
      end
      if (q.size() > 0 && q[0].due <= cyc) begin
        ret_valid <= 1'b1;
        ret_slot  <= q[0].slot;
        ret_gen   <= q[0].gen;
        ret_ok    <= ok_en;
        ret_data  <= DATA_W'({~q[0].addr, q[0].addr});
        void'(q.pop_front());
      end else begin
        // Idle return lines keep toggling so no old value looks valid.
        ret_valid <= 1'b0;
        ret_slot  <= ~ret_slot;
        ret_gen   <= ~ret_gen;
        ret_ok    <= ~ret_ok;
        ret_data  <= ~ret_data;
      end
    end
  end
endmodule

// ---- bench/dpsb_testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dpsb_pkg::*;

  // ****************************************************************
  // Signals, design and far-side model
  // ****************************************************************
  logic                clk, sys_rst, acc_valid, acc_ready, acc_write;
  logic                acc_from_l2, l2_enabled, l2_size_zero, l2_frozen;
  logic                attr_wr, attr_pf_enable, supervisor, rsp_valid;
  logic                fwd_ready, fwd_write, pf_valid, pf_ready, ret_valid;
  logic                ret_ok, pf_en, ok_en, fwd_valid;
  logic [3:0]          lat;
  logic [REGION_W-1:0] attr_idx;
  logic [ADDR_W-1:0]   acc_addr, fwd_addr, pf_addr;
  logic [SLOT_W-1:0]   pf_slot, ret_slot;
  logic [GEN_W-1:0]    pf_gen, ret_gen;
  logic [63:0]         rsp_data, ret_data, rsp_d, fwd_a, fwd_w, npf, pf_s0;
  logic [63:0]         got_rsp, got_fwd;
  logic [63:0]         pf_a [4];
  int                  fails, checked;

  dpsb_top #(.DATA_W(64)) uut (
    .clk(clk), .sys_rst(sys_rst), .acc_valid(acc_valid),
    .acc_ready(acc_ready), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_from_l2(acc_from_l2), .l2_enabled(l2_enabled),
    .l2_size_zero(l2_size_zero), .l2_frozen(l2_frozen), .attr_wr(attr_wr),
    .attr_idx(attr_idx), .attr_pf_enable(attr_pf_enable),
    .supervisor(supervisor),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .fwd_valid(fwd_valid),
    .fwd_ready(fwd_ready), .fwd_addr(fwd_addr), .fwd_write(fwd_write),
    .pf_valid(pf_valid), .pf_ready(pf_ready), .pf_addr(pf_addr),
    .pf_slot(pf_slot), .pf_gen(pf_gen), .ret_valid(ret_valid),
    .ret_slot(ret_slot), .ret_gen(ret_gen), .ret_ok(ret_ok),
    .ret_data(ret_data));

  dpsb_mem_model #(.DATA_W(64)) mem (
    .clk(clk), .sys_rst(sys_rst), .lat(lat), .pf_en(pf_en), .ok_en(ok_en),
    .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .pf_valid(pf_valid),
    .pf_ready(pf_ready), .pf_addr(pf_addr), .pf_slot(pf_slot),
    .pf_gen(pf_gen), .ret_valid(ret_valid), .ret_slot(ret_slot),
    .ret_gen(ret_gen), .ret_ok(ret_ok), .ret_data(ret_data));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  function automatic logic [63:0] dat(input logic [31:0] a);
    return {~a, a};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One demand, held until taken, then n cycles of watching the outputs.
  task automatic access(input logic [31:0] a, input logic wr,
                        input logic l2, input int n);
    int i;
    @(posedge clk);
    acc_valid   <= 1'b1;
    acc_addr    <= a;
    acc_write   <= wr;
    acc_from_l2 <= l2;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (acc_ready === 1'b1) break;
    end
    // A demand never taken counts against the run.
    if (i == 40) fails++;
    @(posedge clk);
    acc_valid <= 1'b0;
    {got_rsp, got_fwd, npf} = '0;
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) {got_rsp, rsp_d} = {64'h1, rsp_data};
      if (fwd_valid === 1'b1) {got_fwd, fwd_a, fwd_w} =
          {64'h1, 64'(fwd_addr), 64'(fwd_write)};
      if (pf_valid === 1'b1 && npf < 4 &&
          (npf == 0 || 64'(pf_addr) !== pf_a[npf-1])) begin
        if (npf == 0) pf_s0 = 64'(pf_slot);
        pf_a[npf] = 64'(pf_addr);
        npf++;
      end
    end
  endtask

  // A miss on base, then its successor, which is the stream trigger.
  task automatic pair(input logic [31:0] base);
    access(base, 1'b0, 1'b0, 6);
    access(base + 64, 1'b0, 1'b0, 12);
  endtask

  task automatic attr(input logic [7:0] idx, input logic en, input logic s);
    @(posedge clk);
    {attr_wr, attr_idx, attr_pf_enable, supervisor} <= {1'b1, idx, en, s};
    @(posedge clk);
    attr_wr <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_stream;
    pair(32'h0c000000);
    check(npf, 2);
    check(pf_a[0], 64'h0c000080);
    check(pf_a[1], 64'h0c0000c0);
    check(pf_s0, 0);
    access(32'h0c000080, 1'b0, 1'b0, 4);
    check(got_rsp, 1);
    check(rsp_d, dat(32'h0c000080));
    check(got_fwd, 0);
    check(npf, 0);
  endtask

  task automatic t_region;
    pair(32'h0b000000);
    check(npf, 0);
    pair(32'h10000000);
    check(npf, 0);
    check(got_fwd, 1);
    attr(8'h10, 1'b1, 1'b0);
    pair(32'h10001000);
    check(npf, 0);
    attr(8'h10, 1'b1, 1'b1);
    pair(32'h10002000);
    check(npf, 2);
    check(pf_s0, 2);
    access(32'h10002080, 1'b1, 1'b0, 6);
    check(fwd_w, 1);
    access(32'h10002080, 1'b0, 1'b0, 6);
    check(got_rsp, 0);
    check(got_fwd, 1);
    attr(8'h10, 1'b0, 1'b1);
    pair(32'h10003000);
    check(npf, 0);
    check(fwd_a, 64'h10003040);
  endtask

  // Failed fetches leave both halves empty; the L1 miss re-fetches the half after it.
  task automatic t_fail;
    ok_en <= 1'b0;
    pair(32'h0f000000);
    ok_en <= 1'b1;
    access(32'h0f000080, 1'b0, 1'b0, 8);
    check(got_rsp, 0);
    check(fwd_a, 64'h0f000080);
    check(npf, 1);
    check(pf_a[0], 64'h0f0000c0);
  endtask

  // The far side stalls, so the second fetch displaces the first.
  task automatic t_stall;
    pf_en <= 1'b0;
    pair(32'h0e000000);
    check(pf_a[1], 64'h0e0000c0);
    access(32'h0e000080, 1'b0, 1'b0, 6);
    check(got_fwd, 1);
    check(got_rsp, 0);
    lat   <= 4'h6;
    pf_en <= 1'b1;
    access(32'h0e0000c0, 1'b0, 1'b0, 20);
    check(got_rsp, 1);
    check(rsp_d, dat(32'h0e0000c0));
    check(got_fwd, 0);
    lat <= 4'h2;
  endtask

  task automatic t_l2;
    logic [31:0] g;
    ok_en <= 1'b0;
    pair(32'h0d000000);
    ok_en <= 1'b1;
    access(32'h0d000080, 1'b0, 1'b1, 8);
    check(npf, 0);
    check(got_fwd, 1);
    for (int i = 0; i < 3; i++) begin
      g = 32'h0d100000 + 32'(i) * 32'h1000;
      ok_en <= 1'b0;
      pair(g);
      @(posedge clk);
      {ok_en, l2_enabled, l2_size_zero, l2_frozen} <= {1'b1, i != 0,
          i == 1, i == 2};
      access(g + 128, 1'b0, 1'b1, 8);
      check(npf, 1);
      check(pf_a[0], 64'(g + 192));
      @(posedge clk);
      {l2_enabled, l2_size_zero, l2_frozen} <= 3'b100;
    end
    pair(32'h0c400000);
    check(pf_s0, 0);
  endtask

  // A stalled look-back fetch leaves just as its slot is reallocated.
  task automatic t_race;
    attr(8'h10, 1'b1, 1'b1);
    pf_en <= 1'b0;
    access(32'h100020c0, 1'b0, 1'b0, 4);
    check(pf_a[0], 64'h10002080);
    access(32'h0e200000, 1'b0, 1'b0, 6);
    // The far side wakes on the very edge that takes the trigger.
    fork
      access(32'h0e200040, 1'b0, 1'b0, 12);
      begin
        @(posedge clk);
        pf_en <= 1'b1;
      end
    join
    check(pf_s0, 2);
    access(32'h0e200080, 1'b0, 1'b0, 6);
    check(got_rsp, 1);
    check(rsp_d, dat(32'h0e200080));
  endtask

  task automatic print_verdict;
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The whole run needs a few hundred cycles; this is far beyond it.
  initial begin
    #100000;
    fails++;
    print_verdict();
  end

  // Main sequence: reset, then every scenario in turn.
  initial begin
    {fails, checked} = '0;
    {sys_rst, l2_enabled, pf_en, ok_en, lat} = {4'hf, 4'h2};
    {acc_valid, acc_write, acc_from_l2, l2_size_zero, l2_frozen} = '0;
    {attr_wr, attr_idx, attr_pf_enable, supervisor, acc_addr} = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_stream();
    t_region();
    t_fail();
    t_stall();
    t_l2();
    t_race();
    print_verdict();
  end
endmodule
